// *** include/hbridge_pkg.sv ***
// Constants, types and register map of the dual H-bridge chopping controller.
// Assumes a 50 ns core clock and a serial link running on its own clock.
// Function
// - Fast decay reverses bridge drive, then coasts when winding current nears zero.
// - Slow decay turns both low-side FETs on to recirculate current.
// - Decay behaviour follows the programmed decay_select field.
// - Fixed-mixed starts fast, turns slow after mixed_transition_time for remaining off time.
// - Auto-mixed samples current at blanking end; above trip goes straight to fast.
// - Auto-mixed fast turns slow once below trip after blanking; off expiry restarts.
// - Auto-mixed below trip at blanking end stays on until trip, then slow.
// - Sense input ignored for blanking: 500 ns plus 20 ns per step.
// - Blanking interval is the minimum on-time of each drive phase.
// - Auto-mixed fast decay ignores trip changes until a blanking interval expires.
// - Each gate change applies peak current for peak_drive_duration, then weak hold.
// - While a high-side FET is on, its leg low-side gate is held low.
// - Digital dead time chosen by dead_time_select separates high and low conduction.
// - Overcurrent recognised when FET voltage exceeds threshold longer than the deglitch time.
// - Overcurrent disables bridge, sets its flag, asserts fault_out_n; latched until written zero.
// - Gate fault disables bridge, sets gate_fault_flag, asserts fault_out_n; latched until written zero.
// - Overtemperature stops all FETs and sets flag; recovery clears flag, then releases fault.
// - Supply undervoltage stops all FETs and sets flag; recovery clears flag, then releases fault.
// - Serial frame is 16 bits: read/write bit, 3 address bits, 12 data bits.
// - Read has high first bit and address; later input ignored, data returned.
// - Off state lasts the fixed off time: 525 ns per step, from 525 ns.
// - decay_select codes: 000 slow, 010 fast, 011 fixed-mixed, 101 auto-mixed.
// - mixed_transition_time counts in 525 ns steps.
package hbridge_pkg;
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int BLANK_BASE_NS = 500;
    localparam int BLANK_STEP_NS = 20;
    localparam int OFF_STEP_NS = 525;
    localparam int MIX_STEP_NS = 525;
    localparam int DEAD0_NS = 410;
    localparam int DEAD1_NS = 460;
    localparam int DEAD2_NS = 670;
    localparam int DEAD3_NS = 880;
    localparam int PEAK_BASE_NS = 250;
    localparam int DEGLITCH_BASE_NS = 1000;

    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_LAST = 5'h03;
    localparam logic [4:0] DATA_LAST = 5'h0f;

    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_OFF = 3'h2;
    localparam logic [2:0] ADDR_BLANK = 3'h3;
    localparam logic [2:0] ADDR_DECAY = 3'h4;
    localparam logic [2:0] ADDR_DRIVE = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    localparam logic [11:0] RST_CFG [0:7] = '{12'h301, 12'h0ff, 12'h130, 12'h080,
                                               12'h010, 12'h000, 12'h000, 12'h000};

    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_GAIN_LSB = 8;
    localparam int CTRL_DEAD_LSB = 10;
    localparam int DECAY_MODE_LSB = 8;
    localparam int DRIVE_SRC_LSB = 10;
    localparam int DRIVE_SNK_LSB = 8;
    localparam int DRIVE_TSRC_LSB = 6;
    localparam int DRIVE_TSNK_LSB = 4;
    localparam int DRIVE_DEG_LSB = 2;
    localparam int DRIVE_OCTH_LSB = 0;
    localparam int ST_OVERTEMP = 0;
    localparam int ST_OCP_LSB = 1;
    localparam int ST_GATE_LSB = 3;
    localparam int ST_UNDERVOLT = 5;

    typedef enum logic [2:0] {
        DECAY_SLOW = 3'h0,
        DECAY_FAST = 3'h2,
        DECAY_MIXED = 3'h3,
        DECAY_AUTO = 3'h5
    } decay_mode_t;

    typedef enum logic [3:0] {
        CH_IDLE = 4'h1,
        CH_DRIVE = 4'h2,
        CH_FAST = 4'h4,
        CH_SLOW = 4'h8
    } chop_state_t;

    typedef enum logic [1:0] {
        LEG_OFF = 2'h0,
        LEG_HIGH = 2'h1,
        LEG_LOW = 2'h2
    } leg_drive_t;

    typedef struct packed {
        logic high_on;
        logic low_on;
        logic high_peak;
        logic low_peak;
        logic low_hold;
    } leg_gate_t;

    // Least times round up, never below one cycle
    function automatic logic [11:0] ns_to_cycles(input int ns);
        int c;
        c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[11:0];
    endfunction

    function automatic int dead_ns(input logic [1:0] code);
        case (code)
            2'h0: return DEAD0_NS;
            2'h1: return DEAD1_NS;
            2'h2: return DEAD2_NS;
            default: return DEAD3_NS;
        endcase
    endfunction
endpackage

// *** rtl/hbridge_chop_decay_control.sv ***
// Fixed off-time chopping, decay sequencing, gate timing, faults and serial link.
// Pins are asynchronous to i_clock; the link runs on i_serial_clock.
`timescale 1ns/10ps
module hbridge_chop_decay_control (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Serial configuration link
    input wire logic i_serial_clock,
    input wire logic i_serial_select,
    input wire logic i_serial_data_in,
    output logic o_serial_data_out,
    // Per-bridge commands and comparators, then shared overtemperature and supply-low inputs
    input wire logic [1:0] i_bridge_on,
    input wire logic [1:0] i_bridge_reverse,
    input wire logic [1:0] i_current_trip,
    input wire logic [1:0] i_current_zero,
    input wire logic [1:0] i_fet_overvoltage,
    input wire logic [1:0] i_gate_overcurrent,
    input wire logic i_overtemp,
    input wire logic i_motor_supply_low,
    // Gate pre-driver, legs 0-1 bridge A, legs 2-3 bridge B
    output hbridge_pkg::leg_gate_t [3:0] o_leg_gate,
    output logic [1:0] o_peak_drive_source,
    output logic [1:0] o_peak_drive_sink,
    output logic [1:0] o_overcurrent_threshold,
    output logic [1:0] o_sense_gain,
    output logic o_fault_out_n
);
    // Link domain: frame state is cleared by the frame's own select
    logic frame_rst;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [14:0] shift_in_reg, shift_in_next;
    logic [11:0] out_shift_reg, out_shift_next;
    logic read_reg, read_next;
    logic [2:0] rd_addr;
    logic [11:0] rd_word;
    logic [2:0] wr_addr_reg, wr_addr_next;
    logic [11:0] wr_data_reg, wr_data_next;
    logic wr_toggle_reg, wr_toggle_next;
    logic [11:0] link_cfg_reg [0:7];
    logic [11:0] link_cfg_next [0:7];
    logic [5:0] stat_ls1_reg, stat_ls2_reg;
    logic [5:0] stat_reg, stat_next;

    assign frame_rst = i_rst | ~i_serial_select;

    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        shift_in_next = {shift_in_reg[13:0], i_serial_data_in};
        out_shift_next = {out_shift_reg[10:0], 1'b0};
        read_next = read_reg;
        rd_addr = {shift_in_reg[1:0], i_serial_data_in};
        rd_word = (rd_addr == hbridge_pkg::ADDR_STATUS) ? {6'h00, stat_ls2_reg} : link_cfg_reg[rd_addr];
        if (bit_cnt_reg < hbridge_pkg::FRAME_BITS) begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
        end
        if (bit_cnt_reg == 5'h00) begin
            read_next = i_serial_data_in;
        end
        if (bit_cnt_reg == hbridge_pkg::ADDR_LAST && read_reg) begin
            out_shift_next = rd_word;
        end
    end

    always_ff @(posedge i_serial_clock or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_reg <= 5'h00;
            shift_in_reg <= 15'h0000;
            out_shift_reg <= 12'h000;
            read_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            shift_in_reg <= shift_in_next;
            out_shift_reg <= out_shift_next;
            read_reg <= read_next;
        end
    end

    assign o_serial_data_out = out_shift_reg[11];

    // Written words are held until the next frame, so the core may read them after the toggle
    always_comb begin
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        wr_toggle_next = wr_toggle_reg;
        link_cfg_next = link_cfg_reg;
        if (i_serial_select && bit_cnt_reg == hbridge_pkg::DATA_LAST && !read_reg) begin
            wr_addr_next = shift_in_reg[13:11];
            wr_data_next = {shift_in_reg[10:0], i_serial_data_in};
            wr_toggle_next = ~wr_toggle_reg;
            link_cfg_next[shift_in_reg[13:11]] = {shift_in_reg[10:0], i_serial_data_in};
        end
    end

    always_ff @(posedge i_serial_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_addr_reg <= 3'h0;
            wr_data_reg <= 12'h000;
            wr_toggle_reg <= 1'b0;
            link_cfg_reg <= hbridge_pkg::RST_CFG;
            stat_ls1_reg <= 6'h00;
            stat_ls2_reg <= 6'h00;
        end else begin
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            wr_toggle_reg <= wr_toggle_next;
            link_cfg_reg <= link_cfg_next;
            stat_ls1_reg <= stat_reg;
            stat_ls2_reg <= stat_ls1_reg;
        end
    end

    // Core domain: pin and toggle synchronisers
    logic [13:0] in_s1_reg, in_s2_reg;
    logic wt_s1_reg, wt_s2_reg, wt_s3_reg;
    logic write_event;
    logic [1:0] on_s, rev_s, trip_s, zero_s, ovv_s, gfault_s;
    logic ot_s, uv_s;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            in_s1_reg <= 14'h0000;
            in_s2_reg <= 14'h0000;
            wt_s1_reg <= 1'b0;
            wt_s2_reg <= 1'b0;
            wt_s3_reg <= 1'b0;
        end else begin
            in_s1_reg <= {i_bridge_on, i_bridge_reverse, i_current_trip, i_current_zero,
                          i_fet_overvoltage, i_gate_overcurrent, i_overtemp, i_motor_supply_low};
            in_s2_reg <= in_s1_reg;
            wt_s1_reg <= wr_toggle_reg;
            wt_s2_reg <= wt_s1_reg;
            wt_s3_reg <= wt_s2_reg;
        end
    end

    assign {on_s, rev_s, trip_s, zero_s, ovv_s, gfault_s, ot_s, uv_s} = in_s2_reg;
    assign write_event = wt_s2_reg ^ wt_s3_reg;

    // Configuration copy and status flags
    logic [11:0] cfg_reg [0:7];
    logic [11:0] cfg_next [0:7];
    logic [5:0] stat_clr;
    logic [1:0] ocp_evt;
    logic fault_n_reg, fault_n_next;

    always_comb begin
        cfg_next = cfg_reg;
        stat_clr = 6'h00;
        if (write_event && wr_addr_reg != hbridge_pkg::ADDR_STATUS) begin
            cfg_next[wr_addr_reg] = wr_data_reg;
        end
        if (write_event && wr_addr_reg == hbridge_pkg::ADDR_STATUS) begin
            stat_clr = ~wr_data_reg[5:0];
        end
        // A new event wins over a clear in the same cycle
        stat_next[2:1] = (stat_reg[2:1] & ~stat_clr[2:1]) | ocp_evt;
        stat_next[4:3] = (stat_reg[4:3] & ~stat_clr[4:3]) | gfault_s;
        stat_next[hbridge_pkg::ST_OVERTEMP] = ot_s;
        stat_next[hbridge_pkg::ST_UNDERVOLT] = uv_s;
        // Release waits one cycle after the last flag clears
        fault_n_next = ~((|stat_reg) | (|stat_next));
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cfg_reg <= hbridge_pkg::RST_CFG;
            stat_reg <= 6'h00;
            fault_n_reg <= 1'b1;
        end else begin
            cfg_reg <= cfg_next;
            stat_reg <= stat_next;
            fault_n_reg <= fault_n_next;
        end
    end

    assign o_fault_out_n = fault_n_reg;
    assign o_sense_gain = cfg_reg[hbridge_pkg::ADDR_CTRL][hbridge_pkg::CTRL_GAIN_LSB +: 2];
    assign o_peak_drive_source = cfg_reg[hbridge_pkg::ADDR_DRIVE][hbridge_pkg::DRIVE_SRC_LSB +: 2];
    assign o_peak_drive_sink = cfg_reg[hbridge_pkg::ADDR_DRIVE][hbridge_pkg::DRIVE_SNK_LSB +: 2];
    assign o_overcurrent_threshold = cfg_reg[hbridge_pkg::ADDR_DRIVE][hbridge_pkg::DRIVE_OCTH_LSB +: 2];

    // Timing counts derived from the settings
    logic [11:0] blank_cyc, off_cyc, trans_cyc, dead_cyc, src_cyc, snk_cyc, deg_cyc;
    logic [2:0] mode;
    logic enable;

    always_comb begin
        blank_cyc = hbridge_pkg::ns_to_cycles(hbridge_pkg::BLANK_BASE_NS
            + hbridge_pkg::BLANK_STEP_NS * int'(cfg_reg[hbridge_pkg::ADDR_BLANK][7:0]));
        off_cyc = hbridge_pkg::ns_to_cycles(hbridge_pkg::OFF_STEP_NS
            * (int'(cfg_reg[hbridge_pkg::ADDR_OFF][7:0]) + 1));
        trans_cyc = hbridge_pkg::ns_to_cycles(hbridge_pkg::MIX_STEP_NS
            * int'(cfg_reg[hbridge_pkg::ADDR_DECAY][7:0]));
        dead_cyc = hbridge_pkg::ns_to_cycles(hbridge_pkg::dead_ns(
            cfg_reg[hbridge_pkg::ADDR_CTRL][hbridge_pkg::CTRL_DEAD_LSB +: 2]));
        src_cyc = hbridge_pkg::ns_to_cycles(hbridge_pkg::PEAK_BASE_NS
            << cfg_reg[hbridge_pkg::ADDR_DRIVE][hbridge_pkg::DRIVE_TSRC_LSB +: 2]);
        snk_cyc = hbridge_pkg::ns_to_cycles(hbridge_pkg::PEAK_BASE_NS
            << cfg_reg[hbridge_pkg::ADDR_DRIVE][hbridge_pkg::DRIVE_TSNK_LSB +: 2]);
        deg_cyc = hbridge_pkg::ns_to_cycles(hbridge_pkg::DEGLITCH_BASE_NS
            << cfg_reg[hbridge_pkg::ADDR_DRIVE][hbridge_pkg::DRIVE_DEG_LSB +: 2]);
        mode = cfg_reg[hbridge_pkg::ADDR_DECAY][hbridge_pkg::DECAY_MODE_LSB +: 3];
        enable = cfg_reg[hbridge_pkg::ADDR_CTRL][hbridge_pkg::CTRL_ENABLE];
    end

    // Chopper per bridge
    hbridge_pkg::leg_drive_t leg_dem [0:3];

    for (genvar b = 0; b < 2; b++) begin : g_bridge
        hbridge_pkg::chop_state_t st_reg, st_next;
        logic [11:0] blank_reg, blank_next, off_reg, off_next, deg_reg, deg_next;
        logic run, blank_done, off_done, over, ocp_b;
        hbridge_pkg::leg_drive_t la, lb;

        always_comb begin
            run = enable & on_s[b] & ~stat_reg[hbridge_pkg::ST_OCP_LSB + b]
                & ~stat_reg[hbridge_pkg::ST_GATE_LSB + b] & ~ot_s & ~uv_s;
            blank_done = blank_reg >= blank_cyc;
            off_done = off_reg >= off_cyc - 12'h001;
            over = ovv_s[b] && st_reg != hbridge_pkg::CH_IDLE;
            deg_next = over ? ((deg_reg < deg_cyc) ? deg_reg + 12'h001 : deg_reg) : 12'h000;
            ocp_b = over && deg_reg >= deg_cyc;
            st_next = st_reg;
            blank_next = (blank_reg <= blank_cyc) ? blank_reg + 12'h001 : blank_reg;
            off_next = off_reg + 12'h001;
            case (st_reg)
                hbridge_pkg::CH_IDLE: begin
                    blank_next = 12'h000;
                    off_next = 12'h000;
                    st_next = hbridge_pkg::CH_DRIVE;
                end
                hbridge_pkg::CH_DRIVE: begin
                    off_next = 12'h000;
                    // Trip is only looked at once blanking has run out
                    if (blank_done && trip_s[b]) begin
                        blank_next = 12'h000;
                        if (mode == hbridge_pkg::DECAY_AUTO) begin
                            st_next = (blank_reg == blank_cyc) ? hbridge_pkg::CH_FAST
                                : hbridge_pkg::CH_SLOW;
                        end else if (mode == hbridge_pkg::DECAY_FAST || mode == hbridge_pkg::DECAY_MIXED) begin
                            st_next = hbridge_pkg::CH_FAST;
                        end else begin
                            st_next = hbridge_pkg::CH_SLOW;
                        end
                    end
                end
                hbridge_pkg::CH_FAST: begin
                    if (off_done) begin
                        st_next = hbridge_pkg::CH_DRIVE;
                        blank_next = 12'h000;
                    end else if (mode == hbridge_pkg::DECAY_MIXED && off_reg >= trans_cyc) begin
                        st_next = hbridge_pkg::CH_SLOW;
                    end else if (mode == hbridge_pkg::DECAY_AUTO && blank_done && !trip_s[b]) begin
                        st_next = hbridge_pkg::CH_SLOW;
                    end
                end
                hbridge_pkg::CH_SLOW: begin
                    if (off_done) begin
                        st_next = hbridge_pkg::CH_DRIVE;
                        blank_next = 12'h000;
                    end
                end
                default: begin
                    st_next = hbridge_pkg::CH_IDLE;
                end
            endcase
            if (!run) begin
                st_next = hbridge_pkg::CH_IDLE;
            end
            la = hbridge_pkg::LEG_OFF;
            lb = hbridge_pkg::LEG_OFF;
            case (st_reg)
                hbridge_pkg::CH_DRIVE: begin
                    la = rev_s[b] ? hbridge_pkg::LEG_LOW : hbridge_pkg::LEG_HIGH;
                    lb = rev_s[b] ? hbridge_pkg::LEG_HIGH : hbridge_pkg::LEG_LOW;
                end
                hbridge_pkg::CH_FAST: begin
                    // Coast near zero so the winding never takes reverse current
                    if (!zero_s[b]) begin
                        la = rev_s[b] ? hbridge_pkg::LEG_HIGH : hbridge_pkg::LEG_LOW;
                        lb = rev_s[b] ? hbridge_pkg::LEG_LOW : hbridge_pkg::LEG_HIGH;
                    end
                end
                hbridge_pkg::CH_SLOW: begin
                    la = hbridge_pkg::LEG_LOW;
                    lb = hbridge_pkg::LEG_LOW;
                end
                default: begin
                    la = hbridge_pkg::LEG_OFF;
                end
            endcase
        end

        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                st_reg <= hbridge_pkg::CH_IDLE;
                blank_reg <= 12'h000;
                off_reg <= 12'h000;
                deg_reg <= 12'h000;
            end else begin
                st_reg <= st_next;
                blank_reg <= blank_next;
                off_reg <= off_next;
                deg_reg <= deg_next;
            end
        end

        assign leg_dem[2 * b] = la;
        assign leg_dem[2 * b + 1] = lb;
        // One driver per flag bit, so the two bridges never share a process
        assign ocp_evt[b] = ocp_b;
    end

    // Gate timing per leg
    for (genvar l = 0; l < 4; l++) begin : g_leg
        hbridge_pkg::leg_drive_t app_reg, app_next;
        logic [11:0] dead_reg, dead_next, hpk_reg, hpk_next, lpk_reg, lpk_next;
        hbridge_pkg::leg_gate_t gate_reg, gate_next;
        logic hi_now, lo_now;

        always_comb begin
            app_next = app_reg;
            dead_next = (dead_reg != 12'h000) ? dead_reg - 12'h001 : 12'h000;
            if (leg_dem[l] != app_reg) begin
                if (app_reg != hbridge_pkg::LEG_OFF) begin
                    app_next = hbridge_pkg::LEG_OFF;
                    dead_next = dead_cyc;
                end else if (dead_reg == 12'h000) begin
                    app_next = leg_dem[l];
                end
            end
            hi_now = app_next == hbridge_pkg::LEG_HIGH;
            lo_now = app_next == hbridge_pkg::LEG_LOW;
            hpk_next = (hpk_reg != 12'h000) ? hpk_reg - 12'h001 : 12'h000;
            lpk_next = (lpk_reg != 12'h000) ? lpk_reg - 12'h001 : 12'h000;
            if (hi_now != (app_reg == hbridge_pkg::LEG_HIGH)) begin
                hpk_next = hi_now ? src_cyc : snk_cyc;
            end
            if (lo_now != (app_reg == hbridge_pkg::LEG_LOW)) begin
                lpk_next = lo_now ? src_cyc : snk_cyc;
            end
            gate_next.high_on = hi_now;
            gate_next.low_on = lo_now;
            gate_next.high_peak = hpk_next != 12'h000;
            gate_next.low_peak = lpk_next != 12'h000;
            gate_next.low_hold = hi_now;
        end

        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                app_reg <= hbridge_pkg::LEG_OFF;
                dead_reg <= 12'h000;
                hpk_reg <= 12'h000;
                lpk_reg <= 12'h000;
                gate_reg <= '0;
            end else begin
                app_reg <= app_next;
                dead_reg <= dead_next;
                hpk_reg <= hpk_next;
                lpk_reg <= lpk_next;
                gate_reg <= gate_next;
            end
        end

        assign o_leg_gate[l] = gate_reg;
    end
endmodule // hbridge_chop_decay_control

// *** bench/hb_asserts.sv ***
// Checker on the top ports of the chopping controller.
// Assumes one core clock domain and an active-high async reset.
`timescale 1ns/10ps
module hb_asserts (
    // Watched ports
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_serial_select,
    input wire logic i_overtemp,
    input wire logic i_motor_supply_low,
    input wire logic o_serial_data_out,
    input wire hbridge_pkg::leg_gate_t [3:0] o_leg_gate,
    input wire logic o_fault_out_n
);
    logic h0, l0, p0;
    logic [3:0] on_a;
    assign h0 = o_leg_gate[0].high_on;
    assign l0 = o_leg_gate[0].low_on;
    assign p0 = o_leg_gate[0].high_peak;
    assign on_a = {o_leg_gate[1][4:3], o_leg_gate[0][4:3]};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    property p_excl; !(h0 && l0); endproperty
    a_excl: assert property (p_excl) else $error("both gates on");
    property p_hold; h0 |-> o_leg_gate[0].low_hold; endproperty
    a_hold: assert property (p_hold) else $error("low side not held");
    property p_dead_hl; $fell(h0) |-> !l0 [*8]; endproperty
    a_dead_hl: assert property (p_dead_hl) else $error("dead time short");
    property p_dead_lh; $fell(l0) |-> !h0 [*8]; endproperty
    a_dead_lh: assert property (p_dead_lh) else $error("dead time short");
    property p_peak_on; $rose(h0) |-> ##[0:1] p0; endproperty
    a_peak_on: assert property (p_peak_on) else $error("no peak drive");
    property p_peak_end; $rose(p0) |-> ##[1:60] !p0; endproperty
    a_peak_end: assert property (p_peak_end) else $error("peak too long");
    property p_halt; (i_overtemp || i_motor_supply_low) [*8] |-> on_a == 4'h0; endproperty
    a_halt: assert property (p_halt) else $error("FET on in fault");
    property p_fault; (i_overtemp || i_motor_supply_low) [*8] |-> !o_fault_out_n; endproperty
    a_fault: assert property (p_fault) else $error("fault pin high");
    property p_sdo; !i_serial_select |-> !o_serial_data_out; endproperty
    a_sdo: assert property (p_sdo) else $error("data out idle");
    c_drive: cover property ($rose(h0));
    c_fault: cover property ($fell(o_fault_out_n));
    c_read: cover property ($rose(o_serial_data_out));
endmodule // hb_asserts

// *** bench/link_model.sv ***
// Serial controller model; its clock runs only inside frames.
// Assumes the device samples on rising link clock.
`timescale 1ns/10ps
module link_model (
    // Link pins
    output logic o_sclk,
    output logic o_sel,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial {o_sclk, o_sel, o_sdi} = 3'b001;
    // Released data flips so a stale bit is never taken as valid
    task automatic frame(input logic [15:0] f, input int n, output logic [11:0] rd);
        rd = 12'h000;
        #7 o_sel = 1'b1;
        for (int k = 0; k < n; k++) begin
            o_sdi = f[15-k];
            #15 o_sclk = 1'b1;
            #15 o_sclk = 1'b0;
            if (k > 2 && k < 15) rd[14-k] = i_sdo;
        end
        o_sel = 1'b0;
        o_sdi = ~o_sdi;
    endtask
endmodule // link_model

// *** bench/tb_top.sv ***
// Bench: link frames plus pin-level chopping and fault scenarios.
// Assumes package, checker and link model compiled first.
`timescale 1ns/10ps
module tb_top;
    logic i_clock, i_rst, sck, sel, sdi, sdo, flt_n, hot, low_vm;
    logic [1:0] on, rev, trip, zero, fovv, gocp, src, snk, octh, gain;
    logic [11:0] rd;
    int error_cnt = 0;
    int total_checks = 0;
    hbridge_pkg::leg_gate_t [3:0] g;
    logic [10:0] tbl [5] = '{11'h055, 11'h290, 11'h395, 11'h555, 11'h595};
    hbridge_chop_decay_control u_hbridge_chop_decay_control (.i_clock(i_clock), .i_rst(i_rst),
        .i_serial_clock(sck), .i_serial_select(sel), .i_serial_data_in(sdi), .o_serial_data_out(sdo),
        .i_bridge_on(on), .i_bridge_reverse(rev), .i_current_trip(trip), .i_current_zero(zero),
        .i_fet_overvoltage(fovv), .i_gate_overcurrent(gocp), .i_overtemp(hot), .i_motor_supply_low(low_vm),
        .o_leg_gate(g), .o_peak_drive_source(src), .o_peak_drive_sink(snk), .o_overcurrent_threshold(octh),
        .o_sense_gain(gain), .o_fault_out_n(flt_n));
    link_model u_link_model (.o_sclk(sck), .o_sel(sel), .o_sdi(sdi), .i_sdo(sdo));
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    function automatic logic [3:0] pt(input int b);
        return {g[2*b+1].high_on, g[2*b+1].low_on, g[2*b].high_on, g[2*b].low_on};
    endfunction
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        u_link_model.frame({1'b0, a, d}, 16, rd);
        cyc(6);
    endtask
    task automatic rc(input logic [2:0] a, input logic [11:0] e);
        u_link_model.frame({1'b1, a, 12'hfff}, 16, rd);
        cyc(1);
        chk(rd, e);
    endtask
    // Bounded poll of a bridge's gate pattern
    task automatic wp(input int b, input logic [3:0] p, input int lim);
        int k;
        k = 0;
        while (pt(b) !== p && k < lim) begin
            cyc(1);
            k++;
        end
        chk({8'h00, pt(b)}, {8'h00, p});
        if (pt(b) !== p) summarize();
    endtask
    initial begin
        i_rst = 1'b1;
        {on, rev, trip, zero, fovv, gocp, hot, low_vm} = 14'h0000;
        cyc(5);
        i_rst = 1'b0;
        cyc(2);
        for (int a = 0; a < 8; a++) rc(a[2:0], hbridge_pkg::RST_CFG[a]);
        wr(hbridge_pkg::ADDR_DRIVE, 12'hb41);
        wr(hbridge_pkg::ADDR_OFF, 12'h10f);
        chk({4'h0, gain, src, snk, octh}, 12'h0ed);
        u_link_model.frame({1'b0, hbridge_pkg::ADDR_DRIVE, 12'h000}, 9, rd);
        rc(hbridge_pkg::ADDR_DRIVE, 12'hb41);
        for (int m = 0; m < 5; m++) begin
            wr(hbridge_pkg::ADDR_DECAY, {1'b0, tbl[m][10:8], 8'h04});
            on = 2'b01;
            wp(0, 4'h6, 300);
            trip = {1'b0, m != 3};
            cyc(40);
            chk({8'h00, pt(0)}, 12'h006);
            cyc(40);
            trip = 2'b01;
            wp(0, tbl[m][7:4], 60);
            trip = 2'b00;
            cyc(10);
            chk({8'h00, pt(0)}, {8'h00, tbl[m][7:4]});
            zero = {1'b0, m == 1};
            wp(0, tbl[m][3:0], 120);
            if (m == 0) begin
                cyc(120);
                chk({8'h00, pt(0)}, 12'h005);
                wp(0, 4'h6, 60);
            end
            {on, zero} = 4'h0;
            wp(0, 4'h0, 300);
        end
        {on, rev} = 4'ha;
        wp(1, 4'h9, 300);
        fovv = 2'b10;
        cyc(12);
        chk({11'h000, flt_n}, 12'h001);
        gocp = 2'b01;
        cyc(20);
        chk({7'h00, flt_n, pt(1)}, 12'h000);
        {on, fovv, gocp} = 6'h00;
        rc(hbridge_pkg::ADDR_STATUS, 12'h00c);
        wr(hbridge_pkg::ADDR_STATUS, 12'h008);
        rc(hbridge_pkg::ADDR_STATUS, 12'h008);
        chk({11'h000, flt_n}, 12'h000);
        wr(hbridge_pkg::ADDR_STATUS, 12'h000);
        chk({11'h000, flt_n}, 12'h001);
        on = 2'b01;
        for (int i = 0; i < 2; i++) begin
            {low_vm, hot} = 2'b01 << i;
            cyc(12);
            chk({7'h00, flt_n, pt(0)}, 12'h000);
            rc(hbridge_pkg::ADDR_STATUS, i ? 12'h020 : 12'h001);
            {low_vm, hot} = 2'b00;
            cyc(6);
            chk({11'h000, flt_n}, 12'h001);
            wp(0, 4'h6, 30);
        end
        summarize();
    end
endmodule // tb_top
bind hbridge_chop_decay_control hb_asserts u_hb_asserts (.i_clock(i_clock), .i_rst(i_rst),
    .i_serial_select(i_serial_select), .i_overtemp(i_overtemp), .i_motor_supply_low(i_motor_supply_low),
    .o_serial_data_out(o_serial_data_out), .o_leg_gate(o_leg_gate), .o_fault_out_n(o_fault_out_n));
